// ===== design/tws_pkg.sv
package tws_pkg;

  // register byte offsets on the bus
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_DATA = 4'h8;

  // control_register field positions
  localparam int CB_DONE = 7;
  localparam int CB_ACKEN = 6;
  localparam int CB_STA = 5;
  localparam int CB_STO = 4;
  localparam int CB_WCOL = 3;
  localparam int CB_EN = 2;

  // status codes, low three bits always zero
  localparam logic [7:0] ST_IDLE = 8'hF8;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_DW_ACK = 8'h28;
  localparam logic [7:0] ST_DW_NACK = 8'h30;
  localparam logic [7:0] ST_ARB = 8'h38;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_DR_ACK = 8'h50;
  localparam logic [7:0] ST_DR_NACK = 8'h58;
  localparam logic [7:0] STAT_MASK = 8'hF8;

  // reset values
  localparam logic [7:0] DATA_RST = 8'hFF;

  // timing: one quarter of an scl period (100 kHz bus)
  localparam int CLK_NS = 25;
  localparam int QUARTER_NS = 2500;
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] Q_LAST = 7'(QUARTER_CYC - 1);

  // bit index of the acknowledge slot
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_START = 2'b01,
    E_BIT = 2'b10,
    E_STOP = 2'b11
  } tws_state_t;

endpackage

// ===== design/tws_sync.sv
module tws_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  // lines idle high, so reset to released
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '1;
      q_o <= '1;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

// ===== design/tws_master.sv
// Chosen here: register access over Wishbone and the register offsets.
module tws_master
  import tws_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oen_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen_o
);

  tws_state_t state;
  logic [1:0] q;
  logic [6:0] cnt;
  logic [3:0] bitn;
  logic [7:0] sh;
  logic [7:0] status;
  logic [7:0] data_r;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;
  logic bus_busy;
  logic op_done;
  logic ack_en;
  logic sta;
  logic sto;
  logic wcol;
  logic en;
  logic owner;
  logic addr_ph;
  logic rx;
  logic acked;
  logic ev_set;
  logic sto_clr;
  logic data_ld;
  logic req;
  logic wr;
  logic wr_ctrl;
  logic wr_data;
  logic go;
  logic tick;
  logic adv;
  logic rxd;
  logic [7:0] rd_val;

  function automatic logic [7:0] code_of(input logic a, input logic r, input logic k);
    logic [7:0] c;
    c = ST_IDLE;
    if (a) begin
      c = r ? (k ? ST_AR_ACK : ST_AR_NACK) : (k ? ST_AW_ACK : ST_AW_NACK);
    end else begin
      c = r ? (k ? ST_DR_ACK : ST_DR_NACK) : (k ? ST_DW_ACK : ST_DW_NACK);
    end
    return c;
  endfunction

  // open-drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  tws_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({scl_i, sda_i}),
    .q_o(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // bus free tracking from start and stop conditions
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bus_busy <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (scl_s && scl_q && sda_q && !sda_s) begin
        bus_busy <= 1'b1;
      end else if (scl_s && scl_q && !sda_q && sda_s) begin
        bus_busy <= 1'b0;
      end
    end
  end

  // wishbone: writes land on the edge that samples ack
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wr_ctrl = wr && (wb_adr_i == ADR_CTRL);
  assign wr_data = wr && (wb_adr_i == ADR_DATA);

  always_comb begin
    case (wb_adr_i)
      ADR_CTRL: rd_val = {op_done, ack_en, sta, sto, wcol, en, 2'b00};
      ADR_STAT: rd_val = status & STAT_MASK;
      ADR_DATA: rd_val = data_r;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= {24'h000000, rd_val};
      end
    end
  end

  // control bits; hardware set wins over software clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_done <= 1'b0;
      ack_en <= 1'b0;
      sta <= 1'b0;
      sto <= 1'b0;
      en <= 1'b0;
    end else begin
      if (ev_set) begin
        op_done <= 1'b1;
      end else if (wr_ctrl && wb_dat_i[CB_DONE]) begin
        op_done <= 1'b0;
      end
      if (wr_ctrl) begin
        ack_en <= wb_dat_i[CB_ACKEN];
        en <= wb_dat_i[CB_EN];
        sta <= wb_dat_i[CB_STA] & wb_dat_i[CB_EN];
        sto <= wb_dat_i[CB_STO] & wb_dat_i[CB_EN];
      end
      if (sto_clr) begin
        sto <= 1'b0;
      end
    end
  end

  // data register and collision flag
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_r <= DATA_RST;
      wcol <= 1'b0;
    end else begin
      if (data_ld) begin
        data_r <= sh;
      end else if (wr_data && op_done) begin
        data_r <= wb_dat_i[7:0];
      end
      if (wr_data && !op_done) begin
        wcol <= 1'b1;
      end else if (wr_data) begin
        wcol <= 1'b0;
      end
    end
  end

  // quarter-period timer; stretches while a slave holds scl
  assign tick = (cnt == Q_LAST);
  assign adv = tick && ((q != 2'd1) || scl_s);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 7'h00;
    end else if (state == E_IDLE || adv) begin
      cnt <= 7'h00;
    end else if (!tick) begin
      cnt <= cnt + 7'h01;
    end
  end

  assign go = en & ~op_done & ~ev_set;
  assign rxd = rx & ~addr_ph;

  // bus engine
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= E_IDLE;
      q <= 2'd0;
      bitn <= 4'h0;
      sh <= 8'h00;
      status <= ST_IDLE;
      owner <= 1'b0;
      addr_ph <= 1'b0;
      rx <= 1'b0;
      acked <= 1'b0;
      ev_set <= 1'b0;
      sto_clr <= 1'b0;
      data_ld <= 1'b0;
      scl_oen_o <= 1'b1;
      sda_oen_o <= 1'b1;
    end else begin
      ev_set <= 1'b0;
      sto_clr <= 1'b0;
      data_ld <= 1'b0;
      if (!en) begin
        state <= E_IDLE;
        owner <= 1'b0;
        scl_oen_o <= 1'b1;
        sda_oen_o <= 1'b1;
      end else begin
        case (state)
          E_IDLE: begin
            q <= 2'd0;
            if (go && sto && owner) begin
              state <= E_STOP;
              sda_oen_o <= 1'b0;
            end else if (go && sto) begin
              sto_clr <= 1'b1;
            end else if (go && sta && (owner || !bus_busy)) begin
              state <= E_START;
              sda_oen_o <= 1'b1;
            end else if (go && owner && !sta) begin
              state <= E_BIT;
              bitn <= 4'h0;
              sh <= data_r;
              if (addr_ph) begin
                rx <= data_r[0];
                sda_oen_o <= data_r[7];
              end else begin
                sda_oen_o <= rx | data_r[7];
              end
            end
          end
          E_START: begin
            if (adv) begin
              q <= q + 2'd1;
              case (q)
                2'd0: scl_oen_o <= 1'b1;
                2'd1: sda_oen_o <= 1'b0;
                2'd2: scl_oen_o <= 1'b0;
                default: begin
                  state <= E_IDLE;
                  ev_set <= 1'b1;
                  status <= owner ? ST_RSTART : ST_START;
                  owner <= 1'b1;
                  addr_ph <= 1'b1;
                end
              endcase
            end
          end
          E_BIT: begin
            if (adv) begin
              q <= q + 2'd1;
              case (q)
                2'd0: scl_oen_o <= 1'b1;
                2'd1: begin
                  if (bitn == ACK_BIT) begin
                    acked <= ~sda_s;
                  end else if (!rxd && sda_oen_o && !sda_s) begin
                    state <= E_IDLE;
                    owner <= 1'b0;
                    scl_oen_o <= 1'b1;
                    ev_set <= 1'b1;
                    status <= ST_ARB;
                  end else begin
                    sh <= {sh[6:0], sda_s};
                  end
                end
                2'd2: scl_oen_o <= 1'b0;
                default: begin
                  if (bitn == ACK_BIT) begin
                    state <= E_IDLE;
                    ev_set <= 1'b1;
                    status <= code_of(addr_ph, rx, acked);
                    data_ld <= 1'b1;
                    addr_ph <= 1'b0;
                    sda_oen_o <= 1'b1;
                  end else begin
                    bitn <= bitn + 4'h1;
                    if (bitn == ACK_BIT - 4'h1) begin
                      sda_oen_o <= ~(rxd & ack_en);
                    end else begin
                      sda_oen_o <= rxd | sh[7];
                    end
                  end
                end
              endcase
            end
          end
          E_STOP: begin
            if (adv) begin
              q <= q + 2'd1;
              case (q)
                2'd0: scl_oen_o <= 1'b1;
                2'd1: sda_oen_o <= 1'b1;
                2'd2: owner <= 1'b0;
                default: begin
                  state <= E_IDLE;
                  sto_clr <= 1'b1;
                end
              endcase
            end
          end
          default: state <= E_IDLE;
        endcase
      end
    end
  end

endmodule

// ===== test/tws_master_sva.sv
module tws_master_sva
  import tws_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic scl_o,
  input wire logic scl_oen_o,
  input wire logic sda_o,
  input wire logic sda_oen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic en_q;
  logic done_q;
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = wb_ack_o && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0];
  assign ctl_rd = wb_ack_o && !wb_we_i && wb_adr_i == ADR_CTRL;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_q <= 1'b0;
    end else if (ctl_wr) begin
      en_q <= wb_dat_i[CB_EN];
    end
  end
  // single-master view: an arbitration loss would release scl with the flag up
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_q <= 1'b0;
    end else if (ctl_wr && wb_dat_i[CB_DONE]) begin
      done_q <= 1'b0;
    end else if (ctl_rd && wb_dat_o[CB_DONE]) begin
      done_q <= 1'b1;
    end
  end
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  stat_low_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADR_STAT |->
    (wb_dat_o[7:0] & ~STAT_MASK) == 8'h00)
    else $error("status low bits not zero");
  ctrl_low_a: assert property (ctl_rd |-> wb_dat_o[1:0] == 2'b00)
    else $error("control low bits not zero");
  line_drive_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("line output not open drain");
  off_release_a: assert property (!en_q [*3] |-> scl_oen_o && sda_oen_o)
    else $error("lines driven while disabled");
  held_low_a: assert property (done_q |-> !scl_oen_o)
    else $error("scl released while flag set");
  cover property (done_q);
  cover property (ctl_wr && wb_dat_i[CB_STO]);
  cover property (ctl_wr && wb_dat_i[CB_STA] && wb_dat_i[CB_STO]);
endmodule

bind tws_master tws_master_sva chk_u (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .scl_o(scl_o), .scl_oen_o(scl_oen_o), .sda_o(sda_o), .sda_oen_o(sda_oen_o));

// ===== test/tws_slave_model.sv
module tws_slave_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_i,
  output logic sda_oen_o,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  int bits;
  initial begin
    sda_oen_o = 1'b1;
    bits = 0;
    sh = 8'h00;
    byte_o = 8'h00;
  end
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      bits = 0;
    end
  end
  always @(posedge scl_i) begin
    if (bits < 8) begin
      sh = {sh[6:0], sda_i};
    end
    bits = bits + 1;
  end
  always @(negedge scl_i) begin
    if (bits == 8) begin
      byte_o = sh;
      sda_oen_o = ~ack_i;
    end else if (bits >= 9) begin
      sda_oen_o = 1'b1;
      bits = 0;
    end
  end
endmodule

// ===== test/tws_master_test.sv
module tws_master_test
  import tws_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rstn_i, cyc, stb, we, ack, scl_oen, sda_oen, slv_oen, slv_ack, scl_l, sda_l;
  logic [3:0] adr, sel, sel_use;
  logic [31:0] wdat, rdat, q;
  logic [7:0] b, slv_byte;
  int errors, num_checks;
  int seed = 32'h4dd3b35a;
  assign scl_l = scl_oen;
  assign sda_l = sda_oen & slv_oen;
  tws_master dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl_l), .scl_o(), .scl_oen_o(scl_oen),
    .sda_i(sda_l), .sda_o(), .sda_oen_o(sda_oen));
  tws_slave_model slv_u (.scl_i(scl_l), .sda_i(sda_l), .ack_i(slv_ack), .sda_oen_o(slv_oen), .byte_o(slv_byte));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // status code expected after an address or data byte
  function automatic logic [7:0] exp_code(input logic adr_b, input logic rd, input logic k);
    case ({adr_b, rd, k})
      3'b101: return ST_AW_ACK;
      3'b100: return ST_AW_NACK;
      3'b111: return ST_AR_ACK;
      3'b110: return ST_AR_NACK;
      3'b001: return ST_DW_ACK;
      3'b000: return ST_DW_NACK;
      3'b011: return ST_DR_ACK;
      default: return ST_DR_NACK;
    endcase
  endfunction
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_use;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 50) errors++;
  endtask
  task automatic expect_rd(input logic [3:0] a, input logic [7:0] e, input string what);
    wb(1'b0, a, 8'h00);
    chk(what, {24'h000000, e}, q);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    q = 32'h0;
    while (q[CB_DONE] !== 1'b1 && n < 3000) begin
      wb(1'b0, ADR_CTRL, 8'h00);
      n++;
    end
    if (n >= 3000) errors++;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // limit well above the longest sequence of bytes and polls
  initial begin
    #(80000 * 25);
    errors++;
    give_verdict();
  end
  initial begin
    rstn_i = 1'b0;
    {cyc, stb, we, adr, sel, wdat, slv_ack} = '0;
    sel_use = 4'hF;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    expect_rd(ADR_CTRL, 8'h00, "ctrl reset");
    expect_rd(ADR_STAT, ST_IDLE, "stat reset");
    expect_rd(ADR_DATA, DATA_RST, "data reset");
    expect_rd(4'hC, 8'h00, "unmapped");
    wb(1'b1, ADR_DATA, 8'h5A);
    expect_rd(ADR_DATA, DATA_RST, "data discarded");
    expect_rd(ADR_CTRL, 8'h08, "collision set");
    // low byte lane off: the write must not land
    sel_use = 4'hE;
    wb(1'b1, ADR_CTRL, 8'h84);
    sel_use = 4'hF;
    expect_rd(ADR_CTRL, 8'h08, "lane off ignored");
    wb(1'b1, ADR_CTRL, 8'hA0);
    repeat (500) @(posedge clk_i);
    expect_rd(ADR_CTRL, 8'h08, "disabled start");
    chk("lines off", 32'h3, 32'({scl_oen, sda_oen}));
    slv_ack <= 1'b1;
    wb(1'b1, ADR_CTRL, 8'hA4);
    wait_done();
    expect_rd(ADR_STAT, ST_START, "start code");
    repeat (200) @(posedge clk_i);
    chk("scl held", 32'h0, 32'(scl_oen));
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      if (i == 0) b[0] = 1'b0;
      wb(1'b1, ADR_DATA, b);
      wb(1'b1, ADR_CTRL, 8'h84);
      wait_done();
      chk("ctrl after byte", 32'h84, q);
      expect_rd(ADR_STAT, exp_code(i == 0, 1'b0, 1'b1), "byte code");
      chk("wire byte", 32'(b), 32'(slv_byte));
    end
    wb(1'b1, ADR_CTRL, 8'hA4);
    wait_done();
    expect_rd(ADR_STAT, ST_RSTART, "rstart code");
    slv_ack <= 1'b0;
    wb(1'b1, ADR_DATA, 8'($random(seed)) & 8'hFE);
    wb(1'b1, ADR_CTRL, 8'h84);
    wait_done();
    expect_rd(ADR_STAT, exp_code(1'b1, 1'b0, 1'b0), "nack code");
    slv_ack <= 1'b1;
    wb(1'b1, ADR_CTRL, 8'hA4);
    wait_done();
    expect_rd(ADR_STAT, ST_RSTART, "second rstart");
    wb(1'b1, ADR_DATA, 8'($random(seed)) | 8'h01);
    wb(1'b1, ADR_CTRL, 8'h84);
    wait_done();
    expect_rd(ADR_STAT, exp_code(1'b1, 1'b1, 1'b1), "read address code");
    wb(1'b1, ADR_CTRL, 8'hB4);
    wait_done();
    chk("stop bit cleared", 32'h0, 32'(q[CB_STO]));
    expect_rd(ADR_STAT, ST_START, "start after stop");
    wb(1'b1, ADR_CTRL, 8'h94);
    repeat (800) @(posedge clk_i);
    expect_rd(ADR_CTRL, 8'h04, "no flag after stop");
    chk("bus free", 32'h3, 32'({scl_oen, sda_oen}));
    give_verdict();
  end
endmodule
